// ### logic/dlfp_regs.vh
// constants for the drive limit and replacement service parameter bank
`ifndef DLFP_REGS_VH
`define DLFP_REGS_VH
// ------------------------------------------------------------
// parameter addresses (fieldbus word addresses)
// ------------------------------------------------------------
`define DLFP_ADDR_QSTP_CUR    16'h110a
`define DLFP_ADDR_HALT_CUR    16'h110c
`define DLFP_ADDR_MOTOR_CUR   16'h1202
`define DLFP_ADDR_SPEED       16'h1204
`define DLFP_ADDR_REPL_EN     16'h1a28
`define DLFP_ADDR_AUTOSAVE    16'h1a2a
`define DLFP_ADDR_PWD_RESET   16'h1a30
// ------------------------------------------------------------
// ranges and reset values
// ------------------------------------------------------------
`define DLFP_MOTOR_CUR_MAX    16'h752f
`define DLFP_SPEED_MAX        16'h3390
`define DLFP_REPL_EN_MAX      16'h0001
`define DLFP_AUTOSAVE_MAX     16'h0005
`define DLFP_PWD_RESET_MAX    16'h0001
`define DLFP_PWD_RESET_CMD    16'h0001
`define DLFP_REPL_EN_RST      16'h0000
`define DLFP_AUTOSAVE_RST     16'h0000
// ------------------------------------------------------------
// autosave timing
// ------------------------------------------------------------
`define DLFP_CLK_HZ           34'h5f5e100
// a minute of cycles needs 33 bits, so the product is built at 34 bits
`define DLFP_MIN_CYCLES       (34'h3c * `DLFP_CLK_HZ)
`define DLFP_PER1_MIN         7'h01
`define DLFP_PER2_MIN         7'h05
`define DLFP_PER3_MIN         7'h0f
`define DLFP_PER4_MIN         7'h1e
`define DLFP_PER5_MIN         7'h3c
// ------------------------------------------------------------
// access channels
// ------------------------------------------------------------
`define DLFP_CH_RTU           2'h0
`endif

// ### logic/dlfp_bank.v
// fieldbus parameter bank: current and speed limits, replacement service, password reset
// Contract
// - writing 1 to web_password_reset restores the factory web password.
// - after a password reset the next client must set a new password first.
// - web_password_reset is written only over the rtu channel, other channels are refused.
// - autosave 0 is off, 1..5 select 1, 5, 15, 30 and 60 minutes.
// - with the service on and a period set, the configuration is pushed every period.
// - replacement_service_enable is a global 0/1 switch that resets to 0.
// - with a node name and the service on, the configuration is fetched from the server.
// - a received configuration is checked for compatibility before the mode resumes.
// - under the service the network address comes only from the node name.
// - the effective motor current limit is clamped to what motor and power stage permit.
// - quick stop current is held in 0.01 A steps, bounded and defaulted by motor data.
// - halt current is held in 0.01 A steps, bounded by motor data.
// - the motor stops along a ramp or at the quick stop or halt current.
// - every written value takes effect at once.
`timescale 1ns/10ps
`include "dlfp_regs.vh"

module dlfp_bank #(
  parameter [33:0] MIN_CYCLES = `DLFP_MIN_CYCLES,
  parameter [15:0] PWR_STAGE_PEAK = 16'h2710
) (
  input  wire        i_core_clk,
  input  wire        i_nrst,
  input  wire        i_wr,
  input  wire        i_rd,
  input  wire [15:0] i_addr,
  input  wire [15:0] i_wdata,
  input  wire [1:0]  i_channel,
  input  wire [15:0] i_motor_peak_current,
  input  wire [15:0] i_motor_max_speed,
  input  wire        i_node_name_valid,
  input  wire        i_client_new_pwd_set,
  input  wire        i_cfg_received,
  input  wire        i_cfg_compatible,
  input  wire        i_quick_stop_req,
  input  wire        i_halt_req,
  output reg  [15:0] o_rdata,
  output reg         o_ack,
  output reg         o_err,
  output reg         o_pwd_restore,
  output reg         o_pwd_change_required,
  output reg         o_cfg_push,
  output reg         o_cfg_fetch,
  output reg         o_cfg_apply,
  output reg         o_mode_resume,
  output reg         o_addr_by_name_only,
  output reg  [15:0] o_motor_current_eff,
  output reg  [15:0] o_quick_stop_current_eff,
  output reg  [15:0] o_halt_current_eff,
  output reg  [15:0] o_speed_limit_eff,
  output reg  [15:0] o_decel_current,
  output reg         o_decel_at_current
);

  // ------------------------------------------------------------
  // stored parameters
  // ------------------------------------------------------------
  reg  [15:0] motor_cur_r;
  reg  [15:0] qstp_cur_r;
  reg  [15:0] halt_cur_r;
  reg  [15:0] speed_r;
  reg         repl_en_r;
  reg  [2:0]  autosave_r;
  reg         motor_cur_set_r;
  reg         qstp_cur_set_r;
  reg         halt_cur_set_r;
  reg         speed_set_r;
  reg         pwd_pending_r;
  reg         fetch_done_r;
  reg  [6:0]  min_cnt_r;
  reg  [6:0]  period_min;
  reg  [33:0] cyc_cnt_r;
  wire        min_tick;

  // permissible peak: smaller of motor rating and power stage rating
  wire [15:0] perm_max = (i_motor_peak_current < PWR_STAGE_PEAK) ? i_motor_peak_current : PWR_STAGE_PEAK;

  // ------------------------------------------------------------
  // write range check
  // ------------------------------------------------------------
  reg         in_range;
  reg         mapped;
  always @* begin
    in_range = 1'b0;
    mapped = 1'b1;
    case (i_addr)
      `DLFP_ADDR_MOTOR_CUR: in_range = (i_wdata <= `DLFP_MOTOR_CUR_MAX);
      `DLFP_ADDR_QSTP_CUR:  in_range = (i_wdata <= perm_max);
      `DLFP_ADDR_HALT_CUR:  in_range = (i_wdata <= perm_max);
      `DLFP_ADDR_SPEED:     in_range = (i_wdata <= `DLFP_SPEED_MAX);
      `DLFP_ADDR_REPL_EN:   in_range = (i_wdata <= `DLFP_REPL_EN_MAX);
      `DLFP_ADDR_AUTOSAVE:  in_range = (i_wdata <= `DLFP_AUTOSAVE_MAX);
      `DLFP_ADDR_PWD_RESET: in_range = (i_wdata <= `DLFP_PWD_RESET_MAX) &&
                                       (i_channel == `DLFP_CH_RTU);
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  wire wr_ok = i_wr && mapped && in_range;

  // ------------------------------------------------------------
  // parameter storage, effective at once
  // ------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      motor_cur_r     <= 16'h0000;
      qstp_cur_r      <= 16'h0000;
      halt_cur_r      <= 16'h0000;
      speed_r         <= 16'h0000;
      repl_en_r       <= 1'b0;
      autosave_r      <= 3'h0;
      motor_cur_set_r <= 1'b0;
      qstp_cur_set_r  <= 1'b0;
      halt_cur_set_r  <= 1'b0;
      speed_set_r     <= 1'b0;
    end else if (wr_ok) begin
      case (i_addr)
        `DLFP_ADDR_MOTOR_CUR: begin
          motor_cur_r     <= i_wdata;
          motor_cur_set_r <= 1'b1;
        end
        `DLFP_ADDR_QSTP_CUR: begin
          qstp_cur_r     <= i_wdata;
          qstp_cur_set_r <= 1'b1;
        end
        `DLFP_ADDR_HALT_CUR: begin
          halt_cur_r     <= i_wdata;
          halt_cur_set_r <= 1'b1;
        end
        `DLFP_ADDR_SPEED: begin
          speed_r     <= i_wdata;
          speed_set_r <= 1'b1;
        end
        `DLFP_ADDR_REPL_EN:  repl_en_r  <= i_wdata[0];
        `DLFP_ADDR_AUTOSAVE: autosave_r <= i_wdata[2:0];
        default: begin
          motor_cur_r <= motor_cur_r;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // effective limits (motor data may change, so recomputed every cycle)
  // ------------------------------------------------------------
  reg  [15:0] mcur_eff;
  reg  [15:0] qcur_eff;
  reg  [15:0] hcur_eff;
  reg  [15:0] spd_eff;
  always @* begin
    mcur_eff = motor_cur_set_r ? motor_cur_r : i_motor_peak_current;
    if (mcur_eff > perm_max) begin
      mcur_eff = perm_max;
    end
    qcur_eff = qstp_cur_set_r ? qstp_cur_r : perm_max;
    if (qcur_eff > perm_max) begin
      qcur_eff = perm_max;
    end
    hcur_eff = halt_cur_set_r ? halt_cur_r : perm_max;
    if (hcur_eff > perm_max) begin
      hcur_eff = perm_max;
    end
    spd_eff = speed_set_r ? speed_r : i_motor_max_speed;
    if (spd_eff > i_motor_max_speed) begin
      spd_eff = i_motor_max_speed;
    end
  end

  // ------------------------------------------------------------
  // register read and bus answer
  // ------------------------------------------------------------
  reg [15:0] rd_mux;
  always @* begin
    case (i_addr)
      `DLFP_ADDR_MOTOR_CUR: rd_mux = motor_cur_set_r ? motor_cur_r : mcur_eff;
      `DLFP_ADDR_QSTP_CUR:  rd_mux = qcur_eff;
      `DLFP_ADDR_HALT_CUR:  rd_mux = hcur_eff;
      `DLFP_ADDR_SPEED:     rd_mux = speed_set_r ? speed_r : spd_eff;
      `DLFP_ADDR_REPL_EN:   rd_mux = {15'h0000, repl_en_r};
      `DLFP_ADDR_AUTOSAVE:  rd_mux = {13'h0000, autosave_r};
      default:              rd_mux = 16'h0000;
    endcase
  end

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 16'h0000;
      o_ack   <= 1'b0;
      o_err   <= 1'b0;
    end else begin
      o_ack   <= wr_ok || (i_rd && mapped);
      o_err   <= (i_wr && !wr_ok) || (i_rd && !mapped);
      o_rdata <= i_rd ? rd_mux : 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // web password reset
  // ------------------------------------------------------------
  wire pwd_cmd = wr_ok && (i_addr == `DLFP_ADDR_PWD_RESET) &&
                 (i_wdata == `DLFP_PWD_RESET_CMD);
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pwd_restore         <= 1'b0;
      pwd_pending_r         <= 1'b0;
      o_pwd_change_required <= 1'b0;
    end else begin
      o_pwd_restore <= pwd_cmd;
      // a new reset in the same cycle as the client update wins
      if (pwd_cmd) begin
        pwd_pending_r <= 1'b1;
      end else if (i_client_new_pwd_set) begin
        pwd_pending_r <= 1'b0;
      end
      o_pwd_change_required <= pwd_cmd || (pwd_pending_r && !i_client_new_pwd_set);
    end
  end

  // ------------------------------------------------------------
  // autosave timer: one-minute enable, then minute count
  // ------------------------------------------------------------
  always @* begin
    case (autosave_r)
      3'h1:    period_min = `DLFP_PER1_MIN;
      3'h2:    period_min = `DLFP_PER2_MIN;
      3'h3:    period_min = `DLFP_PER3_MIN;
      3'h4:    period_min = `DLFP_PER4_MIN;
      3'h5:    period_min = `DLFP_PER5_MIN;
      default: period_min = 7'h00;
    endcase
  end

  wire autosave_on = repl_en_r && (period_min != 7'h00);
  assign min_tick = (cyc_cnt_r == (MIN_CYCLES - 34'h1));

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cyc_cnt_r  <= 34'h000000000;
      min_cnt_r  <= 7'h00;
      o_cfg_push <= 1'b0;
    end else begin
      o_cfg_push <= 1'b0;
      // changing period or switching off restarts the interval
      if (!autosave_on || (wr_ok && (i_addr == `DLFP_ADDR_AUTOSAVE))) begin
        cyc_cnt_r <= 34'h000000000;
        min_cnt_r <= 7'h00;
      end else if (min_tick) begin
        cyc_cnt_r <= 34'h000000000;
        if (min_cnt_r == period_min - 7'h01) begin
          min_cnt_r  <= 7'h00;
          o_cfg_push <= 1'b1;
        end else begin
          min_cnt_r <= min_cnt_r + 7'h01;
        end
      end else begin
        cyc_cnt_r <= cyc_cnt_r + 34'h000000001;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration fetch and apply
  // ------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fetch_done_r        <= 1'b0;
      o_cfg_fetch         <= 1'b0;
      o_cfg_apply         <= 1'b0;
      o_mode_resume       <= 1'b0;
      o_addr_by_name_only <= 1'b0;
    end else begin
      o_addr_by_name_only <= repl_en_r;
      o_cfg_fetch <= repl_en_r && i_node_name_valid && !fetch_done_r;
      if (!repl_en_r || !i_node_name_valid) begin
        fetch_done_r <= 1'b0;
      end else if (i_cfg_received) begin
        fetch_done_r <= 1'b1;
      end
      o_cfg_apply   <= i_cfg_received && i_cfg_compatible;
      o_mode_resume <= i_cfg_received && i_cfg_compatible;
    end
  end

  // ------------------------------------------------------------
  // limit outputs and deceleration selection
  // ------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_motor_current_eff      <= 16'h0000;
      o_quick_stop_current_eff <= 16'h0000;
      o_halt_current_eff       <= 16'h0000;
      o_speed_limit_eff        <= 16'h0000;
      o_decel_current          <= 16'h0000;
      o_decel_at_current       <= 1'b0;
    end else begin
      o_motor_current_eff      <= mcur_eff;
      o_quick_stop_current_eff <= qcur_eff;
      o_halt_current_eff       <= hcur_eff;
      o_speed_limit_eff        <= spd_eff;
      // quick stop takes priority over halt; with neither request, ramp deceleration
      o_decel_at_current <= i_quick_stop_req || i_halt_req;
      o_decel_current    <= i_quick_stop_req ? qcur_eff :
                            (i_halt_req ? hcur_eff : 16'h0000);
    end
  end

endmodule

// ### verification/dlfp_bank_checker.sv
// concurrent checks on the parameter bank ports
`timescale 1ns/10ps
`include "dlfp_regs.vh"
module dlfp_bank_checker (
  input wire logic        i_core_clk,
  input wire logic        i_nrst,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [1:0]  i_channel,
  input wire logic        i_client_new_pwd_set,
  input wire logic        i_quick_stop_req,
  input wire logic        i_halt_req,
  input wire logic        o_ack,
  input wire logic        o_err,
  input wire logic [15:0] o_rdata,
  input wire logic        o_pwd_restore,
  input wire logic        o_pwd_change_required,
  input wire logic        o_cfg_push,
  input wire logic        o_addr_by_name_only,
  input wire logic        o_decel_at_current
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  wire pwd_wr   = i_wr && i_addr == `DLFP_ADDR_PWD_RESET;
  wire en_wr    = i_wr && i_addr == `DLFP_ADDR_REPL_EN;
  wire stop_any = i_quick_stop_req || i_halt_req;
  // ------------------------------------------------------------
  // password reset steps
  // ------------------------------------------------------------
  sequence s_pwd_cmd;
    pwd_wr && i_wdata == 16'h0001 && i_channel == `DLFP_CH_RTU;
  endsequence
  sequence s_restored;
    o_ack && o_pwd_restore && o_pwd_change_required;
  endsequence
  AST_PWD_RESTORE: assert property (s_pwd_cmd |=> s_restored)
    else $error("password command not answered by restore");
  AST_PWD_CHANNEL: assert property (pwd_wr && i_channel != `DLFP_CH_RTU |=> o_err && !o_pwd_restore)
    else $error("password write from other channel not refused");
  AST_PWD_HOLD: assert property (o_pwd_change_required && !i_client_new_pwd_set |=> o_pwd_change_required)
    else $error("password change demand dropped early");
  AST_PWD_CLEAR: assert property (o_pwd_change_required && i_client_new_pwd_set && !pwd_wr
    |=> !o_pwd_change_required)
    else $error("password change demand not cleared");
  AST_PWD_READ: assert property (i_rd && i_addr == `DLFP_ADDR_PWD_RESET |=> o_ack && o_rdata == 16'h0000)
    else $error("password register read not zero");
  // the enable reaches the port one cycle after the answer
  AST_EN_REFUSE: assert property (en_wr && i_wdata > 16'h0001
    |=> o_err ##1 $stable(o_addr_by_name_only))
    else $error("out of range enable write changed state");
  AST_EN_EFFECT: assert property (en_wr && i_wdata <= 16'h0001
    |=> o_ack ##1 o_addr_by_name_only == $past(i_wdata[0], 2))
    else $error("enable write not effective at once");
  AST_PUSH_ENABLED: assert property (o_cfg_push |-> o_addr_by_name_only)
    else $error("configuration pushed while service off");
  AST_DECEL: assert property (1'b1 |=> o_decel_at_current == $past(stop_any))
    else $error("stop mode does not follow stop requests");
  AST_ONE_ANSWER: assert property (i_wr || i_rd |=> o_ack != o_err)
    else $error("access without exactly one answer");
endmodule
bind dlfp_bank dlfp_bank_checker u_chk (.*);

// ### verification/dlfp_master.sv
// fieldbus master model issuing single-word parameter accesses
`timescale 1ns/10ps
module dlfp_master (
  input  wire logic        i_core_clk,
  input  wire logic        i_ack,
  input  wire logic        i_err,
  input  wire logic [15:0] i_rdata,
  output logic             o_wr,
  output logic             o_rd,
  output logic [15:0]      o_addr,
  output logic [15:0]      o_wdata,
  output logic [1:0]       o_channel
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 16'h0;
    o_wdata = 16'h0;
    o_channel = 2'h0;
  end
  // released bus shows inverted values so a stale word never looks valid
  task automatic xfer(input logic w, input logic [15:0] a, d, input logic [1:0] c,
                      output logic [1:0] r, output logic [15:0] q);
    @(posedge i_core_clk);
    o_wr <= w;
    o_rd <= ~w;
    o_addr <= a;
    o_wdata <= d;
    o_channel <= c;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
    #1;
    r = {i_ack, i_err};
    q = i_rdata;
  endtask
endmodule

// ### verification/drive_limit_and_fdr_params_bench.sv
// self-checking bench for the parameter bank
`timescale 1ns/10ps
`include "dlfp_regs.vh"
module drive_limit_and_fdr_params_bench;
  localparam int       MINC = 10;
  localparam [1:0]     OK = 2'h2;
  localparam [1:0]     ER = 2'h1;
  logic        i_core_clk = 1'b0, i_nrst = 1'b0, i_wr, i_rd, i_node_name_valid = 1'b1;
  logic        i_client_new_pwd_set = 1'b0, i_cfg_received = 1'b0, i_cfg_compatible = 1'b0;
  logic        i_quick_stop_req = 1'b0, i_halt_req = 1'b0, o_ack, o_err, o_pwd_restore;
  logic        o_pwd_change_required, o_cfg_push, o_cfg_fetch, o_cfg_apply, o_mode_resume;
  logic        o_addr_by_name_only, o_decel_at_current;
  logic [1:0]  i_channel;
  logic [15:0] i_addr, i_wdata, o_rdata, o_motor_current_eff, o_quick_stop_current_eff;
  logic [15:0] o_halt_current_eff, o_speed_limit_eff, o_decel_current;
  logic [15:0] i_motor_peak_current = 16'h1388, i_motor_max_speed = 16'h1f40;
  int          n_fail = 0, checks_done = 0, pushes = 0;
  int          per[6] = '{0, 1, 5, 15, 30, 60};
  always #5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) if (o_cfg_push === 1'b1) pushes++;
  dlfp_bank #(.MIN_CYCLES(MINC)) DUT (.*);
  dlfp_master MST (.i_core_clk(i_core_clk), .i_ack(o_ack), .i_err(o_err), .i_rdata(o_rdata),
                   .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata), .o_channel(i_channel));
  // ------------------------------------------------------------
  // access and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, d, input logic [1:0] c, exp);
    logic [1:0]  r;
    logic [15:0] q;
    MST.xfer(1'b1, a, d, c, r, q);
    chk("write response", {14'h0, exp}, {14'h0, r});
    // limits and flags show the new value one cycle after the answer
    @(posedge i_core_clk);
    #1;
  endtask
  task automatic rdc(input logic [15:0] a, exp);
    logic [1:0]  r;
    logic [15:0] q;
    MST.xfer(1'b0, a, 16'h0, 2'h0, r, q);
    chk("read response", {14'h0, OK}, {14'h0, r});
    chk("read data", exp, q);
  endtask
  task automatic pulse(input int sel);
    @(posedge i_core_clk);
    if (sel == 0) i_client_new_pwd_set <= 1'b1;
    else i_cfg_received <= 1'b1;
    @(posedge i_core_clk);
    i_client_new_pwd_set <= 1'b0;
    i_cfg_received <= 1'b0;
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #50000;
    n_fail++;
    close_out();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    @(posedge i_core_clk);
    #1;
    chk("motor eff", 16'h1388, o_motor_current_eff);
    chk("qstop eff", 16'h1388, o_quick_stop_current_eff);
    chk("speed eff", 16'h1f40, o_speed_limit_eff);
    rdc(`DLFP_ADDR_REPL_EN, `DLFP_REPL_EN_RST);
    rdc(`DLFP_ADDR_AUTOSAVE, `DLFP_AUTOSAVE_RST);
    wr(`DLFP_ADDR_PWD_RESET, 16'h1, 2'h1, ER);
    chk("pwd change", 16'h0, {15'h0, o_pwd_change_required});
    wr(`DLFP_ADDR_PWD_RESET, 16'h1, 2'h0, OK);
    chk("pwd change", 16'h1, {15'h0, o_pwd_change_required});
    wr(`DLFP_ADDR_PWD_RESET, 16'h2, 2'h0, ER);
    rdc(`DLFP_ADDR_PWD_RESET, 16'h0);
    chk("pwd change", 16'h1, {15'h0, o_pwd_change_required});
    pulse(0);
    chk("pwd change", 16'h0, {15'h0, o_pwd_change_required});
    wr(`DLFP_ADDR_MOTOR_CUR, 16'h752f, 2'h0, OK);
    chk("motor eff", 16'h1388, o_motor_current_eff);
    wr(`DLFP_ADDR_MOTOR_CUR, 16'h7530, 2'h0, ER);
    wr(`DLFP_ADDR_MOTOR_CUR, 16'h0fa0, 2'h0, OK);
    chk("motor eff", 16'h0fa0, o_motor_current_eff);
    wr(`DLFP_ADDR_SPEED, 16'h1000, 2'h0, OK);
    chk("speed eff", 16'h1000, o_speed_limit_eff);
    wr(`DLFP_ADDR_SPEED, 16'h3391, 2'h0, ER);
    rdc(`DLFP_ADDR_SPEED, 16'h1000);
    wr(`DLFP_ADDR_QSTP_CUR, 16'h1389, 2'h0, ER);
    wr(`DLFP_ADDR_QSTP_CUR, 16'h0800, 2'h0, OK);
    wr(`DLFP_ADDR_HALT_CUR, 16'h0400, 2'h0, OK);
    chk("halt eff", 16'h0400, o_halt_current_eff);
    chk("qstop eff", 16'h0800, o_quick_stop_current_eff);
    wr(16'h1206, 16'h0, 2'h0, ER);
    @(posedge i_core_clk);
    i_quick_stop_req <= 1'b1;
    i_halt_req <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    #1;
    chk("decel cur", 16'h0800, o_decel_current);
    @(posedge i_core_clk);
    i_quick_stop_req <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    #1;
    chk("decel cur", 16'h0400, o_decel_current);
    @(posedge i_core_clk);
    i_halt_req <= 1'b0;
    wr(`DLFP_ADDR_REPL_EN, 16'h2, 2'h0, ER);
    wr(`DLFP_ADDR_REPL_EN, 16'h1, 2'h0, OK);
    chk("by name", 16'h1, {15'h0, o_addr_by_name_only});
    repeat (2) @(posedge i_core_clk);
    #1;
    chk("fetch", 16'h1, {15'h0, o_cfg_fetch});
    pulse(1);
    chk("resume", 16'h0, {15'h0, o_mode_resume});
    chk("apply", 16'h0, {15'h0, o_cfg_apply});
    @(posedge i_core_clk);
    i_cfg_compatible <= 1'b1;
    pulse(1);
    chk("resume", 16'h1, {15'h0, o_mode_resume});
    chk("apply", 16'h1, {15'h0, o_cfg_apply});
    for (int k = 0; k < 7; k++) begin
      wr(`DLFP_ADDR_AUTOSAVE, k[15:0], 2'h0, k < 6 ? OK : ER);
      pushes = 0;
      repeat (105) @(posedge i_core_clk);
      chk("pushes", k == 0 ? 16'h0 : 16'(105 / (per[k > 5 ? 5 : k] * MINC)), pushes[15:0]);
    end
    wr(`DLFP_ADDR_AUTOSAVE, 16'h1, 2'h0, OK);
    wr(`DLFP_ADDR_REPL_EN, 16'h0, 2'h0, OK);
    pushes = 0;
    repeat (105) @(posedge i_core_clk);
    chk("pushes off", 16'h0, pushes[15:0]);
    close_out();
  end
endmodule
